/* File: core/fsp_pkg.sv */
// constants and carriers for the feedback scaling pid loop
package fsp_pkg;
  localparam int          FSP_RAW_W        = 12;
  localparam logic [11:0] FSP_MID          = 12'h800;
  localparam logic [11:0] FSP_FULL         = 12'hfff;
  localparam logic [11:0] FSP_ADC_FULL     = 12'hffc;
  localparam logic [11:0] FSP_MAX_PULSES   = 12'h7ff;
  localparam logic [15:0] FSP_DUTY_MAX     = 16'h0258;
  localparam int          FSP_CLK_HZ       = 25000000;
  localparam int          FSP_PERIOD_MS    = 10;
  localparam int          FSP_PERIOD_CYC   = FSP_CLK_HZ / 1000 * FSP_PERIOD_MS;
  localparam int          FSP_AUX_EVERY    = 16;
  localparam logic [4:0]  FSP_IDEN_MIN     = 5'h03;
  localparam logic [4:0]  FSP_IDEN_MAX     = 5'h12;
  localparam logic [4:0]  FSP_PDEN_MAX     = 5'h0f;
  localparam logic [14:0] FSP_ILIM_MAX     = 15'h7fff;

  typedef enum logic [1:0] {FSP_FB_NONE, FSP_FB_ANALOG, FSP_FB_FREQ} fsp_mode_t;

  typedef struct packed {
    logic [15:0] num;
    logic [4:0]  den_exp;
  } fsp_coef_t;

  typedef struct packed {
    fsp_mode_t   mode;
    logic        invert;
    logic        aux_check;
    logic [11:0] fb_min;
    logic [11:0] fb_max;
    logic [11:0] abs_min;
    logic [11:0] abs_max;
    logic [7:0]  samples;
    logic [14:0] int_limit;
  } fsp_cfg_t;
endpackage : fsp_pkg

/* File: core/fsp_loop.sv */
// feedback acquisition, scaling and pid computation, run once per pid period
// Notes on behaviour
// RL1 - no feedback mode: duty target is target minus 2048, pid skipped
// RL2 - all calculations still run once each pid period without feedback
// RL3 - analog: 0 V reads 0, 5 V reads 4092 raw
// RL4 - frequency mode counts feedback pin pulses per pid period
// RL5 - frequency raw is 2048 plus count forward, minus count reverse
// RL6 - pulse count saturates at 2047 per period
// RL7 - minimum maps to scaled 0, maximum to scaled 4095, linear
// RL8 - raw outside absolute limits raises feedback disconnect error
// RL9 - invert option reverses scaling direction
// RL10 - analog raw is average of configurable sample count per cycle
// RL11 - period exceeded flag when sampling outlasts pid period
// RL12 - aux check drives aux low, feedback must read 0 V
// RL13 - duty target is sum of p, i and d terms
// RL14 - integral sums error, derivative is error minus previous error
// RL15 - error is scaled feedback minus target
// RL16 - coefficients are numerator over power of two
// RL17 - integral denominator exponent limited to 3 through 18
// RL18 - whole sequence paced by configurable pid period
// RL19 - scaled feedback clamped to 0..4095 between configured and absolute limits
// RL20 - duty target limited to -600..600
// RL21 - integral magnitude bounded by integral limit up to 32767
`timescale 1ns/1ns
module fsp_loop
  import fsp_pkg::*;
#(
  parameter int PERIOD_CYC = FSP_PERIOD_CYC
) (
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire fsp_cfg_t    cfg_i,
  input  wire fsp_coef_t   kp_i,
  input  wire fsp_coef_t   ki_i,
  input  wire fsp_coef_t   kd_i,
  input  wire logic [11:0] target_i,
  input  wire logic        fb_pulse_i,
  input  wire logic        adc_valid_i,
  input  wire logic [11:0] adc_data_i,
  output logic             adc_start_o,
  output logic             aux_low_o,
  output logic [11:0]      raw_fb_o,
  output logic [11:0]      scaled_fb_o,
  output logic [15:0]      duty_target_o,
  output logic             fb_disconnect_o,
  output logic             period_exceeded_o,
  output logic             cycle_done_o
);
  typedef enum {ST_IDLE, ST_SAMPLE, ST_SCALE, ST_PID, ST_OUT} st_t;
  st_t st_q;

  logic [31:0] tick_cnt_q;
  logic        tick;
  logic [11:0] pulse_cnt_q;
  logic [11:0] pulse_hold_q;
  logic        pulse_d1_q;
  logic [19:0] acc_q;
  logic [7:0]  samp_q;
  logic        adc_busy_q;
  logic [3:0]  aux_cnt_q;
  logic        aux_fail_q;
  logic [11:0] raw_q;
  logic signed [13:0] err_q;
  logic signed [13:0] prev_err_q;
  logic signed [31:0] integ_q;
  logic signed [47:0] sum_q;

  // signed term: value*num >>> exponent, exponent capped per coefficient
  function automatic logic signed [47:0] term(input logic signed [31:0] v,
                                              input fsp_coef_t c,
                                              input logic [4:0] lo,
                                              input logic [4:0] hi);
    logic [4:0] e;
    e = (c.den_exp < lo) ? lo : ((c.den_exp > hi) ? hi : c.den_exp);
    term = ($signed(48'(v)) * $signed({1'b0, c.num})) >>> e;
  endfunction : term

  // pid period pacing
  assign tick = (tick_cnt_q == 32'(PERIOD_CYC - 1));
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tick_cnt_q <= '0;
    end else if (tick) begin  // see RL18
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h1;
    end
  end

  // pulse counting, one count per rising edge, saturating; the finished
  // period's count is held so scaling never sees a freshly cleared counter
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pulse_d1_q   <= 1'b0;
      pulse_cnt_q  <= '0;
      pulse_hold_q <= '0;
    end else begin
      pulse_d1_q <= fb_pulse_i;
      if (tick) begin
        pulse_hold_q <= pulse_cnt_q;  // see RL4
        pulse_cnt_q  <= (fb_pulse_i && !pulse_d1_q) ? 12'h001 : 12'h000;
      end else if (fb_pulse_i && !pulse_d1_q && pulse_cnt_q != FSP_MAX_PULSES) begin
        pulse_cnt_q <= pulse_cnt_q + 12'h1;  // see RL6
      end
    end
  end

  // sequencer
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= ST_IDLE;
    end else begin
      unique case (st_q)
        ST_IDLE:   if (tick) st_q <= (cfg_i.mode == FSP_FB_ANALOG) ? ST_SAMPLE : ST_SCALE;
        ST_SAMPLE: if (!adc_busy_q && samp_q >= cfg_i.samples) st_q <= ST_SCALE;
        ST_SCALE:  st_q <= ST_PID;
        ST_PID:    st_q <= ST_OUT;
        ST_OUT:    st_q <= ST_IDLE;
      endcase
    end
  end

  // analog sampling and averaging; sample count is a power of two is not assumed
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      acc_q       <= '0;
      samp_q      <= '0;
      adc_busy_q  <= 1'b0;
      adc_start_o <= 1'b0;
    end else begin
      adc_start_o <= 1'b0;
      if (st_q == ST_IDLE) begin
        acc_q  <= '0;
        samp_q <= '0;
      end else if (st_q == ST_SAMPLE) begin
        if (adc_valid_i && adc_busy_q) begin
          acc_q      <= acc_q + 20'(adc_data_i);  // see RL3, RL10
          samp_q     <= samp_q + 8'h1;
          adc_busy_q <= 1'b0;
        end else if (!adc_busy_q && samp_q < cfg_i.samples) begin
          adc_start_o <= 1'b1;
          adc_busy_q  <= 1'b1;
        end
      end
    end
  end

  // overrun: a new period tick while still sampling
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      period_exceeded_o <= 1'b0;
    end else if (tick) begin
      period_exceeded_o <= (st_q == ST_SAMPLE);  // see RL11
    end
  end

  // aux disconnect check: every 16th period all samples of that period are taken with aux low
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      aux_cnt_q  <= '0;
      aux_low_o  <= 1'b0;
      aux_fail_q <= 1'b0;
    end else begin
      if (tick) begin
        aux_cnt_q <= aux_cnt_q + 4'h1;
        aux_low_o <= cfg_i.aux_check && cfg_i.mode == FSP_FB_ANALOG
                     && aux_cnt_q == 4'(FSP_AUX_EVERY - 1);  // see RL12
        aux_fail_q <= 1'b0;
      end
      if (aux_low_o && st_q == ST_SAMPLE && adc_valid_i && adc_busy_q
          && adc_data_i != 12'h000) begin
        aux_fail_q <= 1'b1;  // see RL12
      end
    end
  end

  // raw feedback, scaling, disconnect and error
  logic [11:0] avg;
  logic [11:0] raw_n;
  logic [12:0] span;
  logic [24:0] num;
  logic [11:0] scaled_n;
  always_comb begin
    avg = (cfg_i.samples == 8'h00) ? 12'h000 : 12'(acc_q / 20'(cfg_i.samples));
    unique case (cfg_i.mode)
      FSP_FB_ANALOG: raw_n = avg;
      FSP_FB_FREQ:   raw_n = (target_i > FSP_MID) ? FSP_MID + pulse_hold_q
                                                  : FSP_MID - pulse_hold_q;  // see RL5
      default:       raw_n = '0;
    endcase
    span = {1'b0, cfg_i.fb_max} - {1'b0, cfg_i.fb_min};
    if (raw_n <= cfg_i.fb_min) begin
      num = '0;  // see RL19
    end else if (raw_n >= cfg_i.fb_max) begin
      num = 25'(FSP_FULL);
    end else begin
      num = 25'((25'(raw_n - cfg_i.fb_min) * 25'(FSP_FULL)) / 25'(span));  // see RL7
    end
    scaled_n = cfg_i.invert ? FSP_FULL - num[11:0] : num[11:0];  // see RL9
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      raw_q           <= '0;
      raw_fb_o        <= '0;
      scaled_fb_o     <= '0;
      err_q           <= '0;
      prev_err_q      <= '0;
      fb_disconnect_o <= 1'b0;
    end else if (st_q == ST_SCALE) begin
      raw_q       <= raw_n;
      raw_fb_o    <= raw_n;
      scaled_fb_o <= scaled_n;
      prev_err_q  <= err_q;
      err_q       <= $signed({2'b00, scaled_n}) - $signed({2'b00, target_i});  // see RL15
      fb_disconnect_o <= (cfg_i.mode != FSP_FB_NONE)
                         && (raw_n < cfg_i.abs_min || raw_n > cfg_i.abs_max
                             || aux_fail_q);  // see RL8, RL12
    end
  end

  // integral with limit and pid sum
  logic signed [31:0] ilim;
  logic signed [31:0] isum;
  assign ilim = $signed({17'h0, cfg_i.int_limit});
  assign isum = integ_q + 32'(err_q);
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      integ_q <= '0;
      sum_q   <= '0;
    end else if (st_q == ST_PID) begin
      if (cfg_i.mode == FSP_FB_NONE) begin
        integ_q <= '0;
        sum_q   <= $signed({36'h0, target_i}) - $signed({36'h0, FSP_MID});  // see RL1
      end else begin
        if (isum > ilim) integ_q <= ilim;  // see RL21
        else if (isum < -ilim) integ_q <= -ilim;
        else integ_q <= isum;  // see RL14
        sum_q <= term(32'(err_q), kp_i, 5'h00, FSP_PDEN_MAX)
               + term(integ_q, ki_i, FSP_IDEN_MIN, FSP_IDEN_MAX)
               + term(32'(err_q - prev_err_q), kd_i, 5'h00, FSP_PDEN_MAX);  // see RL13, RL16, RL17
      end
    end
  end

  // duty limit and completion strobe
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      duty_target_o <= '0;
      cycle_done_o  <= 1'b0;
    end else begin
      cycle_done_o <= (st_q == ST_OUT);  // see RL2
      if (st_q == ST_OUT) begin
        if (sum_q > $signed(48'(FSP_DUTY_MAX))) duty_target_o <= FSP_DUTY_MAX;  // see RL20
        else if (sum_q < -$signed(48'(FSP_DUTY_MAX))) duty_target_o <= -FSP_DUTY_MAX;
        else duty_target_o <= sum_q[15:0];
      end
    end
  end

  done_per_tick_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    tick && st_q == ST_IDLE && cfg_i.mode != FSP_FB_ANALOG |-> ##4 cycle_done_o)
    else $error("cycle not completed after tick");  // see RL2
  duty_range_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    $signed(duty_target_o) <= 600 && $signed(duty_target_o) >= -600)
    else $error("duty target out of range");  // see RL20
  pulse_sat_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    pulse_cnt_q <= FSP_MAX_PULSES)
    else $error("pulse count above limit");  // see RL6
  integ_bound_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    $past(st_q == ST_PID) |-> integ_q <= ilim && integ_q >= -ilim)
    else $error("integral exceeds limit");  // see RL21
  overrun_flag_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    tick && st_q == ST_SAMPLE |=> period_exceeded_o)
    else $error("overrun not flagged");  // see RL11
  none_duty_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    st_q == ST_PID && cfg_i.mode == FSP_FB_NONE && $stable(target_i)
    |=> ##1 $signed(duty_target_o) == $signed({4'h0, $past(target_i, 2)}) - 2048)
    else $error("bypass duty mismatch");  // see RL1
  abs_disc_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    st_q == ST_SCALE && cfg_i.mode != FSP_FB_NONE && raw_n > cfg_i.abs_max
    |=> fb_disconnect_o)
    else $error("disconnect not raised");  // see RL8
  err_calc_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    $past(st_q == ST_SCALE) |-> err_q == $signed({2'b00, scaled_fb_o})
    - $signed({2'b00, $past(target_i)}))
    else $error("error value wrong");  // see RL15
  scaled_range_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    st_q == ST_SCALE && !cfg_i.invert && raw_n >= cfg_i.fb_max |=> scaled_fb_o == FSP_FULL)
    else $error("scaled not clamped high");  // see RL19

  analog_cycle_c: cover property (@(posedge core_clk_i) disable iff (rst_i)
    st_q == ST_SAMPLE ##1 st_q == ST_SCALE);
  freq_cycle_c: cover property (@(posedge core_clk_i) disable iff (rst_i)
    cfg_i.mode == FSP_FB_FREQ && cycle_done_o);
  aux_fail_c: cover property (@(posedge core_clk_i) disable iff (rst_i)
    aux_fail_q && fb_disconnect_o);
endmodule : fsp_loop

/* File: tb/fsp_sensor.sv */
// far-side model: feedback pot behind an adc, answers promptly or slowly
`timescale 1ns/1ns
module fsp_sensor (
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic        adc_start_i,
  input  wire logic        aux_low_i,
  input  wire logic        slow_i,
  input  wire logic        open_i,
  input  wire logic [11:0] level_i,
  output logic             adc_valid_o,
  output logic [11:0]      adc_data_o
);
  logic [5:0] wait_q;
  logic       busy_q;
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_q      <= 1'b0;
      wait_q      <= 6'h00;
      adc_valid_o <= 1'b0;
      adc_data_o  <= 12'h000;
    end else begin
      adc_valid_o <= 1'b0;
      // result is not held after valid, so a stale read shows up
      adc_data_o  <= ~adc_data_o;
      if (adc_start_i) begin
        busy_q <= 1'b1;
        wait_q <= slow_i ? 6'h0f : 6'h01;
      end else if (busy_q && wait_q != 6'h00) begin
        wait_q <= wait_q - 6'h01;
      end else if (busy_q) begin
        busy_q      <= 1'b0;
        adc_valid_o <= 1'b1;
        // a wiper still attached reads 0 V while aux is pulled low
        adc_data_o  <= (aux_low_i && !open_i) ? 12'h000 : level_i;
      end
    end
  end
endmodule : fsp_sensor

/* File: tb/testbench.sv */
// self-checking bench for the pid loop: random periods plus corner cases
`timescale 1ns/1ns
module testbench;
  import fsp_pkg::*;
  localparam int PER = 50;
  logic        core_clk_i = 1'b0;
  logic        rst_i      = 1'b1;
  fsp_cfg_t    cfg;
  fsp_coef_t   kp, ki, kd;
  logic [11:0] target, level, raw_fb, scaled_fb, adc_data;
  logic [15:0] duty;
  logic        fb_pulse, adc_start, adc_valid, aux_low, disc, exceeded, done;
  logic        slow, open_pin, aux_seen;
  int          n_fail, checks_done, pdiv, k, w;
  int          pcnt = 0;
  int          prev_err;
  int          divs[6] = '{0, 2, 5, 10, 25, 50};
  always #20 core_clk_i = ~core_clk_i;
  fsp_loop #(.PERIOD_CYC(PER)) fsp_loop_inst (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .cfg_i(cfg), .kp_i(kp), .ki_i(ki), .kd_i(kd), .target_i(target), .fb_pulse_i(fb_pulse),
    .adc_valid_i(adc_valid), .adc_data_i(adc_data), .adc_start_o(adc_start),
    .aux_low_o(aux_low), .raw_fb_o(raw_fb), .scaled_fb_o(scaled_fb), .duty_target_o(duty),
    .fb_disconnect_o(disc), .period_exceeded_o(exceeded), .cycle_done_o(done));
  fsp_sensor fsp_sensor_inst (.core_clk_i(core_clk_i), .rst_i(rst_i), .adc_start_i(adc_start),
    .aux_low_i(aux_low), .slow_i(slow), .open_i(open_pin), .level_i(level),
    .adc_valid_o(adc_valid), .adc_data_o(adc_data));
  // one-cycle pulse every pdiv clocks; pdiv divides the period so counts are exact
  always @(posedge core_clk_i) begin
    pcnt = (pdiv == 0 || pcnt >= pdiv - 1) ? 0 : pcnt + 1;
    fb_pulse <= #2 (pdiv != 0 && pcnt == 0);
    if (aux_low === 1'b1) aux_seen = 1'b1;
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  function automatic logic [15:0] clampd(input int d);
    d = (d > 600) ? 600 : (d < -600) ? -600 : d;
    return d[15:0];
  endfunction : clampd
  function automatic logic [15:0] raw_exp(input int kind);
    int n;
    n = (pdiv == 0) ? 0 : PER / pdiv;
    if (kind == 1) return {4'h0, level};
    return (target > FSP_MID) ? 16'(2048 + n) : 16'(2048 - n);
  endfunction : raw_exp
  function automatic logic [15:0] scaled_exp(input logic [15:0] r);
    logic [15:0] s;
    s = (r <= cfg.fb_min) ? 16'h0000 : (r >= cfg.fb_max) ? 16'h0fff : r;
    return cfg.invert ? 16'h0fff - s : s;
  endfunction : scaled_exp
  function automatic logic [15:0] duty_exp(input int e);
    return clampd(((int'(kp.num) * e) >>> kp.den_exp) +
                  ((int'(kd.num) * (e - prev_err)) >>> kd.den_exp));
  endfunction : duty_exp
  task automatic wait_done(output int n);
    n = 0;
    do begin
      @(posedge core_clk_i);
      #1;
      n++;
    end while (done !== 1'b1 && n < 4000);
  endtask : wait_done
  task automatic run(input int kind, input int n);
    int c, e;
    logic [15:0] r, s;
    // latency depends on converter speed, so it is fixed for a whole run
    slow = 1'($urandom % 2);
    wait_done(c);
    wait_done(c);
    prev_err = int'(scaled_exp(raw_exp(kind))) - int'(target);
    repeat (n) begin
      #1;
      target = (kind == 0) ? 12'(1448 + $urandom % 1201) : 12'($urandom % 4096);
      level = 12'($urandom % 4093);
      r = raw_exp(kind);
      s = scaled_exp(r);
      e = int'(s) - int'(target);
      wait_done(c);
      check("period", 16'(c), 16'(PER));
      if (kind == 0) begin
        check("duty", duty, clampd(int'(target) - 2048));
      end else begin
        check("raw", {4'h0, raw_fb}, r);
        check("scaled", {4'h0, scaled_fb}, s);
        check("duty", duty, duty_exp(e));
        prev_err = e;
      end
      check("disconnect", {15'h0, disc},
            {15'h0, kind != 0 && (r < cfg.abs_min || r > cfg.abs_max)});
      if (kind == 1) check("exceeded", {15'h0, exceeded}, 16'h0000);
    end
    #1;
  endtask : run
  task automatic tally_and_finish();
    if (n_fail == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    #2000000;
    n_fail++;
    tally_and_finish();
  end
  initial begin
    cfg = '0;
    kp = '0;
    ki = '0;
    kd = '0;
    target = FSP_MID;
    level = 12'h000;
    {slow, open_pin, aux_seen, fb_pulse} = 4'h0;
    {n_fail, checks_done, pdiv} = '0;
    void'($urandom(89274));
    cfg.abs_max = FSP_FULL;
    cfg.fb_max = FSP_FULL;
    cfg.samples = 8'h02;
    cfg.int_limit = FSP_ILIM_MAX;
    repeat (6) @(posedge core_clk_i);
    #2 rst_i = 1'b0;
    run(0, 8);
    cfg.mode = FSP_FB_FREQ;
    kp = '{16'h0001, 5'h00};
    foreach (divs[i]) begin
      pdiv = divs[i];
      run(2, 4);
    end
    // derivative only, inverted, then a narrow window that clamps and trips
    kp = '0;
    kd = '{16'h0002, 5'h01};
    cfg.invert = 1'b1;
    pdiv = 5;
    run(2, 6);
    cfg.invert = 1'b0;
    cfg.fb_min = 12'h7f8;
    cfg.fb_max = 12'h802;
    cfg.abs_min = 12'h7fd;
    run(2, 8);
    cfg.fb_min = 12'h000;
    cfg.fb_max = FSP_FULL;
    cfg.abs_min = 12'h000;
    cfg.mode = FSP_FB_ANALOG;
    run(1, 8);
    cfg.samples = 8'hc8;
    slow = 1'b1;
    for (k = 0; k < 400 && exceeded !== 1'b1; k++) @(posedge core_clk_i);
    #1 check("exceeded", {15'h0, exceeded}, 16'h0001);
    #1 cfg.samples = 8'h02;
    slow = 1'b0;
    cfg.aux_check = 1'b1;
    level = 12'h9c4;
    repeat (40) begin
      wait_done(k);
      check("disconnect", {15'h0, disc}, 16'h0000);
    end
    check("aux drive", {15'h0, aux_seen}, 16'h0001);
    #1 open_pin = 1'b1;
    for (k = 0; k < 40 && disc !== 1'b1; k++) wait_done(w);
    check("disconnect", {15'h0, disc}, 16'h0001);
    tally_and_finish();
  end
endmodule : testbench
